// file: hdl/rss_regs.svh
// Rail startup sequencer constants: timing, rail count, code width, reset values
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_CLK_HZ        10000000
`define RSS_CYC_PER_US    (`RSS_CLK_HZ / 1000000)
`define RSS_T_R13_DLY_US  400
`define RSS_T_R7_DLY_US   32000
`define RSS_T_CHAIN_US    2000
`define RSS_T_R5_DLY_US   0
`define RSS_T_R3_DLY_US   2000
`define RSS_T_SS_LONG_US  400
`define RSS_T_SS_SHORT_US 100
`define RSS_T_RST_MS      40
`define RSS_T_LONGPB_MS   4000
`define RSS_T_RSTPULSE_US 100
`define RSS_NUM_RAILS     13
`define RSS_VCODE_W       6
`define RSS_VCODE_DEF     6'h39

`endif

// file: hdl/rss_pkg.sv
// Rail startup sequencer types
package rss_pkg;
    typedef enum logic [1:0] {RSS_OFF, RSS_DELAY, RSS_RAMP, RSS_ON} rss_rail_st_t;
    typedef enum logic [1:0] {RSS_PB_IDLE, RSS_PB_PRESS, RSS_PB_LONG} rss_pb_st_t;
endpackage : rss_pkg

// file: hdl/rss_timer.sv
// Restartable delay counter: counts while armed, restarts when arm drops
`timescale 1ns/1ps
module rss_timer #(
    parameter int W = 32
) (
    input  wire logic         sys_clk_i, // System clock
    input  wire logic         rst_i,     // Sync reset
    input  wire logic         arm_i,     // Trigger present
    input  wire logic [W-1:0] limit_i,   // Cycles to count
    output logic              done_o     // Count reached while armed
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // Elaboration check: a one-bit counter cannot hold a useful limit
    if (W < 2)
    begin : g_bad_width
        $error("rss_timer width too small");
    end

    // Counter restarts whenever trigger drops
    always_comb
    begin
        next_cnt = cnt;
        if (!arm_i)
            next_cnt = '0;
        else if (cnt < limit_i)
            next_cnt = cnt + W'(1);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    assign done_o = arm_i && (cnt >= limit_i);
endmodule : rss_timer

// file: hdl/rss_rail.sv
// One rail: startup delay, soft-start ramp, then in regulation
`timescale 1ns/1ps
module rss_rail #(
    parameter int DLY_CYC = 1,
    parameter int SS_CYC  = 1
) (
    input  wire logic sys_clk_i, // System clock
    input  wire logic rst_i,     // Sync reset
    input  wire logic en_i,      // Enable condition
    output logic      on_o,      // Output driver enabled
    output logic      good_o     // Soft-start complete
);
    rss_pkg::rss_rail_st_t st;
    rss_pkg::rss_rail_st_t next_st;
    logic                  dly_done;
    logic                  ss_done;

    // Elaboration check: a ramp needs at least one cycle
    if (DLY_CYC < 0 || SS_CYC < 1)
    begin : g_bad_timing
        $error("rss_rail bad timing");
    end

    rss_timer #(.W(32)) u_dly (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .arm_i     (en_i && st == rss_pkg::RSS_DELAY),
        .limit_i   (32'(DLY_CYC)),
        .done_o    (dly_done)
    );
    rss_timer #(.W(32)) u_ss (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .arm_i     (en_i && st == rss_pkg::RSS_RAMP),
        .limit_i   (32'(SS_CYC)),
        .done_o    (ss_done)
    );

    // Enable loss drops the rail from any state
    always_comb
    begin
        next_st = st;
        unique case (st)
            rss_pkg::RSS_OFF:   if (en_i) next_st = rss_pkg::RSS_DELAY;
            rss_pkg::RSS_DELAY: if (!en_i) next_st = rss_pkg::RSS_OFF;
                                else if (dly_done) next_st = rss_pkg::RSS_RAMP;
            rss_pkg::RSS_RAMP:  if (!en_i) next_st = rss_pkg::RSS_OFF;
                                else if (ss_done) next_st = rss_pkg::RSS_ON;
            rss_pkg::RSS_ON:    if (!en_i) next_st = rss_pkg::RSS_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            st <= rss_pkg::RSS_OFF;
        else
            st <= next_st;
    end

    assign on_o   = (st == rss_pkg::RSS_RAMP) || (st == rss_pkg::RSS_ON);
    assign good_o = (st == rss_pkg::RSS_ON);
endmodule : rss_rail

// file: hdl/rss_sequencer.sv
// Rail startup sequencer top: chain, rail 3 gate, faults, reset output
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_sequencer #(
    parameter int N          = `RSS_NUM_RAILS,
    parameter int VW         = `RSS_VCODE_W,
    parameter int CYC_PER_US = `RSS_CYC_PER_US,
    parameter int R13_DLY    = `RSS_T_R13_DLY_US * `RSS_CYC_PER_US,
    parameter int R7_DLY     = `RSS_T_R7_DLY_US * `RSS_CYC_PER_US,
    parameter int CHAIN_DLY  = `RSS_T_CHAIN_US * `RSS_CYC_PER_US,
    parameter int R3_DLY     = `RSS_T_R3_DLY_US * `RSS_CYC_PER_US,
    parameter int RST_DLY    = `RSS_T_RST_MS * 1000 * `RSS_CYC_PER_US,
    parameter int LONGPB_DLY = `RSS_T_LONGPB_MS * 1000 * `RSS_CYC_PER_US
) (
    input  wire logic          sys_clk_i,         // System clock 10 MHz
    input  wire logic          rst_i,             // Sync reset, active high
    input  wire logic          vin_ok_i,          // Input above UVLO
    input  wire logic          wake_input_i,      // Wake level starts chain
    input  wire logic          hold_power_in_i,   // Hold level latches chain
    input  wire logic          rail3_enable_in_i, // Rail 3 enable
    input  wire logic          pushbutton_in_n_i, // Pushbutton, active low
    input  wire logic [N-1:0]  out_low_i,         // Per rail below threshold (bit0=rail 1)
    input  wire logic [N-1:0]  host_on_i,         // Host enable per rail
    input  wire logic [N-1:0]  fault_irq_unmask_i,// Fault interrupt unmask
    input  wire logic [N-1:0]  pg_read_i,         // Host read power-good, pulse
    input  wire logic          vcode_we_i,        // Voltage code write strobe
    input  wire logic [3:0]    vcode_sel_i,       // Rail index 0..N-1
    input  wire logic [VW-1:0] vcode_wdata_i,     // New voltage code
    output logic [N-1:0]       rail_on_o,         // Rail enables
    output logic [N-1:0]       power_good_o,      // Power-good flags
    output logic [N*VW-1:0]    voltage_code_o,    // Voltage codes
    output logic               irq_out_n_o,       // Interrupt, active low
    output logic               reset_out_n_o      // Processor reset, active low
);
    localparam int SS_LONG  = `RSS_T_SS_LONG_US * CYC_PER_US;
    localparam int SS_SHORT = `RSS_T_SS_SHORT_US * CYC_PER_US;
    localparam int PULSE    = `RSS_T_RSTPULSE_US * CYC_PER_US;

    // Elaboration check: the rail map below is fixed at thirteen rails
    if (N != 13 || VW < 1 || CYC_PER_US < 1)
    begin : g_bad_param
        $error("rss_sequencer bad parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Chain latch and pushbutton
    logic                 chain_latched;
    logic                 next_chain_latched;
    rss_pkg::rss_pb_st_t  pb_st;
    rss_pkg::rss_pb_st_t  next_pb_st;
    logic                 pb_long;
    logic                 pb_short_ev;
    logic                 g7;
    logic                 g1;
    logic                 g4;
    logic                 g2;
    logic                 g5;
    logic                 g3;
    logic                 g13;
    logic                 on7;
    logic                 on1;
    logic                 on4;
    logic                 on2;
    logic                 on5;
    logic                 on3;
    logic                 on13;
    logic                 chain_en;

    rss_timer #(.W(32)) u_pb (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .arm_i     (!pushbutton_in_n_i),
        .limit_i   (32'(LONGPB_DLY)),
        .done_o    (pb_long)
    );

    // Long press kills chain and clears its latch; short press fires reset pulse
    always_comb
    begin
        next_pb_st  = pb_st;
        pb_short_ev = 1'b0;
        unique case (pb_st)
            rss_pkg::RSS_PB_IDLE:  if (!pushbutton_in_n_i) next_pb_st = rss_pkg::RSS_PB_PRESS;
            rss_pkg::RSS_PB_PRESS:
                if (pb_long) next_pb_st = rss_pkg::RSS_PB_LONG;
                else if (pushbutton_in_n_i)
                begin
                    next_pb_st  = rss_pkg::RSS_PB_IDLE;
                    pb_short_ev = 1'b1;
                end
            rss_pkg::RSS_PB_LONG:  if (pushbutton_in_n_i) next_pb_st = rss_pkg::RSS_PB_IDLE;
        endcase
    end

    // Hold latches chain; shutdown on long press or hold low with wake low
    always_comb
    begin
        next_chain_latched = chain_latched;
        if (pb_st == rss_pkg::RSS_PB_LONG || (!hold_power_in_i && !wake_input_i))
            next_chain_latched = 1'b0;
        else if (hold_power_in_i && g7)
            next_chain_latched = 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pb_st         <= rss_pkg::RSS_PB_IDLE;
            chain_latched <= 1'b0;
        end
        else
        begin
            pb_st         <= next_pb_st;
            chain_latched <= next_chain_latched;
        end
    end

    // Wake starts chain; latch keeps it after wake drops
    assign chain_en = (pb_st != rss_pkg::RSS_PB_LONG)
                      && (wake_input_i || chain_latched);

    ////////////////////////////////////////////////////////////////////////
    // Rails
    // Always-on rail follows input power alone
    rss_rail #(
        .DLY_CYC (R13_DLY),
        .SS_CYC  (SS_LONG)
    ) u_r13 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (vin_ok_i),
        .on_o      (on13),
        .good_o    (g13)
    );

    // Head of the chain: long wake delay, short ramp
    rss_rail #(
        .DLY_CYC (R7_DLY),
        .SS_CYC  (SS_SHORT)
    ) u_r7 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (chain_en),
        .on_o      (on7),
        .good_o    (g7)
    );

    // Each chained rail waits for its predecessor to be good, so a
    // predecessor that falls out takes every later rail down with it
    rss_rail #(
        .DLY_CYC (CHAIN_DLY),
        .SS_CYC  (SS_LONG)
    ) u_r1 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (chain_en && g7),
        .on_o      (on1),
        .good_o    (g1)
    );

    // Second link of the chain
    rss_rail #(
        .DLY_CYC (CHAIN_DLY),
        .SS_CYC  (SS_LONG)
    ) u_r4 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (chain_en && g1),
        .on_o      (on4),
        .good_o    (g4)
    );

    // Third link of the chain
    rss_rail #(
        .DLY_CYC (CHAIN_DLY),
        .SS_CYC  (SS_LONG)
    ) u_r2 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (chain_en && g4),
        .on_o      (on2),
        .good_o    (g2)
    );

    // Last link starts with no delay; its good flag gates the reset output
    rss_rail #(
        .DLY_CYC (0),
        .SS_CYC  (SS_SHORT)
    ) u_r5 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (chain_en && g2),
        .on_o      (on5),
        .good_o    (g5)
    );

    // Rail 3 drops at once when either input falls; it is not part of
    // the chain latch, so hold alone cannot keep it up
    rss_rail #(
        .DLY_CYC (R3_DLY),
        .SS_CYC  (SS_LONG)
    ) u_r3 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .en_i      (hold_power_in_i && rail3_enable_in_i),
        .on_o      (on3),
        .good_o    (g3)
    );

    ////////////////////////////////////////////////////////////////////////
    // Enables, flags, interrupt, voltage codes, reset
    logic [N-1:0]    seq_on;
    logic [N-1:0]    seq_good;
    logic [N-1:0]    next_rail_on;
    logic [N-1:0]    next_pg;
    logic [N-1:0]    flt_pend;
    logic [N-1:0]    next_flt_pend;
    logic [N*VW-1:0] next_vcode;
    logic [31:0]     rst_cnt;
    logic [31:0]     next_rst_cnt;
    logic [31:0]     pls_cnt;
    logic [31:0]     next_pls_cnt;
    logic            next_rst_n;
    logic            sys_up;

    // Host-only rails are zero here, so 6 and 8..12 stay off until enabled
    assign seq_on   = {on13, 5'h00, on7, 1'b0, on5, on4, on3, on2, on1};
    assign seq_good = {g13, 5'h00, g7, 1'b0, g5, g4, g3, g2, g1};
    assign sys_up   = g5;

    always_comb
    begin
        next_rail_on  = seq_on | host_on_i;
        next_pg       = ~out_low_i & next_rail_on & (seq_good | host_on_i);
        next_vcode    = voltage_code_o;
        next_flt_pend = flt_pend;
        for (int i = 0; i < N; i++)
        begin
            // Clear needs recovery or off, and a read; a new fault wins
            if (pg_read_i[i] && (!rail_on_o[i] || !out_low_i[i]))
                next_flt_pend[i] = 1'b0;
            if (fault_irq_unmask_i[i] && rail_on_o[i] && power_good_o[i] && out_low_i[i])
                next_flt_pend[i] = 1'b1;
        end
        // Codes writable once system is up
        if (vcode_we_i && sys_up && vcode_sel_i < 4'(N))
            next_vcode[vcode_sel_i*VW +: VW] = vcode_wdata_i;
    end

    // Reset output: 40 ms after rail 5 good, plus pulse on short press
    always_comb
    begin
        next_rst_cnt = rst_cnt;
        next_pls_cnt = pls_cnt;
        if (!g5)
            next_rst_cnt = '0;
        else if (rst_cnt < 32'(RST_DLY))
            next_rst_cnt = rst_cnt + 32'h1;
        if (pb_short_ev)
            next_pls_cnt = 32'(PULSE);
        else if (pls_cnt != '0)
            next_pls_cnt = pls_cnt - 32'h1;
        next_rst_n = g5 && (rst_cnt >= 32'(RST_DLY)) && (pls_cnt == '0);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rail_on_o      <= '0;
            power_good_o   <= '0;
            flt_pend       <= '0;
            voltage_code_o <= {N{VW'(`RSS_VCODE_DEF)}};
            irq_out_n_o    <= 1'b1;
            reset_out_n_o  <= 1'b0;
            rst_cnt        <= '0;
            pls_cnt        <= '0;
        end
        else
        begin
            rail_on_o      <= next_rail_on;
            power_good_o   <= next_pg;
            flt_pend       <= next_flt_pend;
            voltage_code_o <= next_vcode;
            irq_out_n_o    <= ~|next_flt_pend;
            reset_out_n_o  <= next_rst_n;
            rst_cnt        <= next_rst_cnt;
            pls_cnt        <= next_pls_cnt;
        end
    end
endmodule : rss_sequencer

// file: bench/rss_sequencer_monitor.sv
// Port-level assertions for the rail startup sequencer
`timescale 1ns/1ps
module rss_sequencer_monitor #(
    parameter int N       = 13,
    parameter int VW      = 6,
    parameter int R13_DLY = 20,
    parameter int RST_DLY = 20
) (
    input wire logic            sys_clk_i,          // Clock
    input wire logic            rst_i,              // Reset
    input wire logic            vin_ok_i,           // Input power present
    input wire logic            wake_input_i,       // Wake level
    input wire logic            hold_power_in_i,    // Hold level
    input wire logic            rail3_enable_in_i,  // Rail 3 enable
    input wire logic [N-1:0]    out_low_i,          // Below threshold
    input wire logic [N-1:0]    host_on_i,          // Host enables
    input wire logic [N-1:0]    fault_irq_unmask_i, // Unmask bits
    input wire logic [N-1:0]    pg_read_i,          // Flag reads
    input wire logic            vcode_we_i,         // Code write
    input wire logic [3:0]      vcode_sel_i,        // Code index
    input wire logic [N-1:0]    rail_on_o,          // Rail enables
    input wire logic [N-1:0]    power_good_o,       // Good flags
    input wire logic [N*VW-1:0] voltage_code_o,     // Codes
    input wire logic            irq_out_n_o,        // Interrupt
    input wire logic            reset_out_n_o       // Reset out
);
    int vin_cnt;
    int next_vin_cnt;
    int r5_cnt;
    int next_r5_cnt;
    ////////////////////////////////////////
    // Trigger age counters; a drop restarts them like the design's delays
    always_comb
    begin
        next_vin_cnt = vin_ok_i ? vin_cnt + 1 : 0;
        next_r5_cnt  = power_good_o[4] ? r5_cnt + 1 : 0;
    end
    always_ff @(posedge sys_clk_i)
    begin
        vin_cnt <= rst_i ? 0 : next_vin_cnt;
        r5_cnt  <= rst_i ? 0 : next_r5_cnt;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_pg_low; $rose(out_low_i[12]) |-> ##[1:2] !power_good_o[12]; endproperty
    a_pg_low: assert property (p_pg_low) else $error("flag high while low");
    property p_irq_set; |(out_low_i & fault_irq_unmask_i & power_good_o) |=> !irq_out_n_o; endproperty
    a_irq_set: assert property (p_irq_set) else $error("fault not raised");
    property p_irq_hold; !irq_out_n_o && !(|pg_read_i) |=> !irq_out_n_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
    property p_code_ref; vcode_we_i && vcode_sel_i > 4'hC |=> $stable(voltage_code_o); endproperty
    a_code_ref: assert property (p_code_ref) else $error("bad index wrote");
    property p_r13_dly; $rose(rail_on_o[12]) |-> vin_cnt >= R13_DLY - 3; endproperty
    a_r13_dly: assert property (p_r13_dly) else $error("rail 13 early");
    property p_chain5; $rose(power_good_o[1]) |-> ##[0:4] rail_on_o[4]; endproperty
    a_chain5: assert property (p_chain5) else $error("rail 5 late");
    property p_r3_off; !(hold_power_in_i && rail3_enable_in_i) |-> ##[1:2] !rail_on_o[2]; endproperty
    a_r3_off: assert property (p_r3_off) else $error("rail 3 stays on");
    property p_chain_off; !hold_power_in_i && !wake_input_i |-> ##[1:3] !rail_on_o[6]; endproperty
    a_chain_off: assert property (p_chain_off) else $error("chain stays on");
    property p_rst_out; $rose(reset_out_n_o) |-> r5_cnt >= RST_DLY - 3; endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset out early");
    property p_spare; !(|(host_on_i & 13'h0FA0)) [*3] |-> !(|(rail_on_o & 13'h0FA0)); endproperty
    a_spare: assert property (p_spare) else $error("spare rail on");
    c_irq: cover property ($fell(irq_out_n_o));
    c_rst: cover property ($rose(reset_out_n_o));
    c_r3: cover property ($fell(rail_on_o[2]));
endmodule : rss_sequencer_monitor

bind rss_sequencer rss_sequencer_monitor #(.N(N), .VW(VW), .R13_DLY(R13_DLY),
    .RST_DLY(RST_DLY)) mon_u (.sys_clk_i, .rst_i, .vin_ok_i, .wake_input_i,
    .hold_power_in_i, .rail3_enable_in_i, .out_low_i, .host_on_i, .fault_irq_unmask_i,
    .pg_read_i, .vcode_we_i, .vcode_sel_i, .rail_on_o, .power_good_o, .voltage_code_o,
    .irq_out_n_o, .reset_out_n_o);

// file: bench/rss_host_model.sv
// Host processor and board wiring around the sequencer
`timescale 1ns/1ps
module rss_host_model (
    input  wire logic sys_clk_i,               // Clock
    input  wire logic rail7_good_i,            // Rail 7 output up
    input  wire logic chain_good_i,            // Chain in regulation
    input  wire logic irq_out_n_i,             // Interrupt, active low
    input  wire logic want_r3_i,               // Bench asks for rail 3
    input  wire logic service_i,               // Bench allows flag reads
    output logic      hold_o,                  // Hold level
    output logic      r3_en_o = 1'b0,          // Rail 3 enable
    output logic [12:0] pg_read_o = 13'h0000   // Flag read pulses
);
    // Hold is pulled up to rail 7, so it falls with that rail
    assign hold_o = rail7_good_i;
    // Rail 3 waits for the chain; reads are spaced so each is one pulse
    always @(negedge sys_clk_i)
    begin
        r3_en_o   <= want_r3_i && chain_good_i;
        pg_read_o <= (service_i && !irq_out_n_i && pg_read_o == 13'h0000) ? 13'h1FFF
                     : 13'h0000;
    end
endmodule : rss_host_model

// file: bench/rss_sequencer_tb.sv
// Self-checking bench for the rail startup sequencer
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_sequencer_tb;
    localparam int D = 20;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, vin_ok_i = 1'b0, wake_input_i = 1'b0;
    logic        pushbutton_in_n_i = 1'b1, vcode_we_i = 1'b0, want_r3 = 1'b0, service = 1'b0;
    logic [3:0]  vcode_sel_i = 4'h0;
    logic [5:0]  vcode_wdata_i = 6'h00;
    logic [12:0] out_low_i = 13'h0000, host_on_i = 13'h0000, fault_irq_unmask_i = 13'h0000;
    logic [12:0] pg_read_i, rail_on_o, power_good_o;
    logic [77:0] voltage_code_o;
    logic        hold_power_in_i, rail3_enable_in_i, irq_out_n_o, reset_out_n_o;
    logic [27:0] obs;
    int          failures = 0;
    int          comparisons = 0;
    int          n;
    int          seq_idx [11] = '{6, 19, 0, 13, 3, 16, 1, 14, 4, 17, 27};
    int          seq_dly [11] = '{D, 1000, D, 4000, D, 4000, D, 4000, 0, 1000, D};
    ////////////////////////////////////////
    // Status bits gathered so one wait task serves them all
    assign obs = {reset_out_n_o, irq_out_n_o, power_good_o, rail_on_o};
    always #50 sys_clk_i = ~sys_clk_i;
    rss_sequencer #(.R13_DLY(D), .R7_DLY(D), .CHAIN_DLY(D), .R3_DLY(D), .RST_DLY(D),
        .LONGPB_DLY(D)) dut_u (.sys_clk_i, .rst_i, .vin_ok_i, .wake_input_i,
        .hold_power_in_i, .rail3_enable_in_i, .pushbutton_in_n_i, .out_low_i, .host_on_i,
        .fault_irq_unmask_i, .pg_read_i, .vcode_we_i, .vcode_sel_i, .vcode_wdata_i,
        .rail_on_o, .power_good_o, .voltage_code_o, .irq_out_n_o, .reset_out_n_o);
    rss_host_model host_u (.sys_clk_i, .rail7_good_i(power_good_o[6]),
        .chain_good_i((power_good_o & 13'h005B) == 13'h005B), .irq_out_n_i(irq_out_n_o),
        .want_r3_i(want_r3), .service_i(service), .hold_o(hold_power_in_i),
        .r3_en_o(rail3_enable_in_i), .pg_read_o(pg_read_i));
    ////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask : cyc
    // Bounded wait; a hang ends the run as a mismatch
    task automatic wait_bit(input int idx, input logic lvl, input int lim);
        n = 0;
        while (obs[idx] !== lvl)
        begin
            @(negedge sys_clk_i);
            n++;
            if (n > lim)
            begin
                failures++;
                end_sim();
            end
        end
    endtask : wait_bit
    // Pipeline slack of a few cycles is allowed around each delay
    task automatic dly(input int idx, input int exp);
        wait_bit(idx, 1'b1, exp + 100);
        chk(n >= exp - 3 && n <= exp + 4, 1'b1);
    endtask : dly
    task automatic wr(input logic [3:0] s, input logic [5:0] d);
        vcode_sel_i = s;
        vcode_wdata_i = d;
        vcode_we_i = 1'b1;
        cyc(1);
        vcode_we_i = 1'b0;
        cyc(1);
    endtask : wr
    ////////////////////////////////////////
    // Main sequence: power-up, chain, codes, rail 3, fault, button
    initial
    begin
        cyc(2);
        rst_i = 1'b0;
        cyc(1);
        chk({reset_out_n_o, irq_out_n_o, rail_on_o}, {2'b01, 13'h0000});
        chk(voltage_code_o, {13{`RSS_VCODE_DEF}});
        vin_ok_i = 1'b1;
        dly(12, D);
        dly(25, 4000);
        $display("test always-on rail done");
        wake_input_i = 1'b1;
        for (int i = 0; i < 11; i++)
            dly(seq_idx[i], seq_dly[i]);
        chk(rail_on_o & 13'h0FA0, 13'h0000);
        wake_input_i = 1'b0;
        cyc(50);
        chk(rail_on_o, 13'h105B);
        $display("test chain done");
        wr(4'h0, 6'h15);
        wr(4'hD, 6'h2A);
        chk(voltage_code_o, {{12{`RSS_VCODE_DEF}}, 6'h15});
        want_r3 = 1'b1;
        dly(2, D + 1);
        want_r3 = 1'b0;
        cyc(4);
        chk(rail_on_o[2], 1'b0);
        $display("test codes and rail 3 done");
        fault_irq_unmask_i[12] = 1'b1;
        out_low_i[12] = 1'b1;
        cyc(3);
        chk({irq_out_n_o, power_good_o[12]}, 2'b00);
        out_low_i[12] = 1'b0;
        cyc(8);
        chk(irq_out_n_o, 1'b0);
        service = 1'b1;
        cyc(4);
        service = 1'b0;
        chk(irq_out_n_o, 1'b1);
        $display("test fault done");
        pushbutton_in_n_i = 1'b0;
        cyc(5);
        pushbutton_in_n_i = 1'b1;
        wait_bit(27, 1'b0, D);
        wait_bit(27, 1'b1, 1100);
        chk(n >= 990 && n <= 1004, 1'b1);
        host_on_i[5] = 1'b1;
        wait_bit(5, 1'b1, 100);
        chk(rail_on_o[5], 1'b1);
        pushbutton_in_n_i = 1'b0;
        cyc(60);
        chk(rail_on_o & 13'h005B, 13'h0000);
        pushbutton_in_n_i = 1'b1;
        cyc(10);
        chk(rail_on_o & 13'h005B, 13'h0000);
        $display("test button done");
        end_sim();
    end
endmodule : rss_sequencer_tb
